// *** core/kmd_consts.svh ***
// Constants for the keypad menu display controller
`ifndef KMD_CONSTS_SVH
`define KMD_CONSTS_SVH

// ==========================================
// Timing
`define KMD_CLK_PERIOD_NS   10
`define KMD_MSG_TIME_MS     1000
`define KMD_DEB_TIME_MS     10
`define KMD_BLINK_TIME_MS   250
`define KMD_MSG_CYCLES      (`KMD_MSG_TIME_MS * 1000000 / `KMD_CLK_PERIOD_NS)
`define KMD_DEB_CYCLES      (`KMD_DEB_TIME_MS * 1000000 / `KMD_CLK_PERIOD_NS)
`define KMD_BLINK_CYCLES    (`KMD_BLINK_TIME_MS * 1000000 / `KMD_CLK_PERIOD_NS)

// ==========================================
// Menu sizes
`define KMD_MON_COUNT       17
`define KMD_GROUP_COUNT     5
`define KMD_CODE_COUNT      64
`define KMD_SIGN_POS        5
`define KMD_FAULT_MAX       22

// ==========================================
// Character codes
`define KMD_CH_BLANK        5'h0A
`define KMD_CH_MINUS        5'h0B
`define KMD_CH_E            5'h0C
`define KMD_CH_N            5'h0D
`define KMD_CH_D            5'h0E
`define KMD_CH_R            5'h0F
`define KMD_CH_O            5'h10
`define KMD_CH_P            5'h11
`define KMD_CH_C            5'h12
`define KMD_CH_S            5'h13
`define KMD_CH_U            5'h14
`define KMD_CH_A            5'h15
`define KMD_CH_L            5'h16
`define KMD_CH_B            5'h17
`define KMD_CH_T            5'h18

`endif

// *** core/kmd_pkg.sv ***
// Types for the keypad menu display controller
package kmd_pkg;

    typedef logic [4:0] kmd_char_t;

    typedef struct packed {
        logic mode;
        logic shift;
        logic up;
        logic down;
        logic set;
    } kmd_keys_t;

    typedef struct packed {
        logic            neg;
        logic [4:0][3:0] digits;
    } kmd_value_t;

    typedef struct packed {
        logic read_only;
        logic pwd_req;
        logic run_lock;
        logic signed_ok;
        logic volatile_only;
        logic restart_req;
        logic command;
    } kmd_attr_t;

    typedef struct packed {
        logic [4:0][4:0] chars;
        logic [4:0]      dp;
    } kmd_disp_t;

    typedef enum logic [2:0] {
        KMD_MSG_SAVED,
        KMD_MSG_READ_ONLY,
        KMD_MSG_BAD_PWD,
        KMD_MSG_INVALID,
        KMD_MSG_RUNNING,
        KMD_MSG_NO_NV,
        KMD_MSG_RESTART,
        KMD_MSG_ABORT
    } kmd_msg_t;

    typedef enum logic [2:0] {
        KMD_ST_MON_SYM,
        KMD_ST_MONITOR,
        KMD_ST_PARAM,
        KMD_ST_SET,
        KMD_ST_MSG
    } kmd_state_t;

endpackage : kmd_pkg

// *** core/kmd_key_edge.sv ***
// Key debouncer with one pulse per debounced press
`timescale 1ns/1ps
`include "kmd_consts.svh"
module kmd_key_edge
    import kmd_pkg::*;
#(
    parameter int N          = 5,
    parameter int DEB_CYCLES = `KMD_DEB_CYCLES
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [N-1:0] key_raw,
    output logic      [N-1:0] press
);
    logic [N-1:0]       stable_reg;
    logic [N-1:0][31:0] count_reg;

    // ==========================================
    // Debounce and press edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stable_reg <= '0;
            count_reg  <= '0;
            press      <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                press[i] <= 1'b0;
                if (key_raw[i] == stable_reg[i]) begin
                    count_reg[i] <= '0;
                end else if (count_reg[i] == 32'(DEB_CYCLES - 1)) begin
                    count_reg[i]  <= '0;
                    stable_reg[i] <= key_raw[i];
                    press[i]      <= key_raw[i];
                end else begin
                    count_reg[i] <= count_reg[i] + 32'h0000_0001;
                end
            end
        end
    end
endmodule : kmd_key_edge

// *** core/kmd_seg_drive.sv ***
// Seven-segment encoder with digit blinking
`timescale 1ns/1ps
`include "kmd_consts.svh"
module kmd_seg_drive
    import kmd_pkg::*;
#(
    parameter int BLINK_CYCLES = `KMD_BLINK_CYCLES
) (
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire kmd_disp_t       disp,
    input  wire logic [4:0]      blink_mask,
    output logic      [4:0][6:0] seg_out,
    output logic      [4:0]      dp_out
);
    logic [31:0] blink_cnt_reg;
    logic        blink_off_reg;

    function automatic logic [6:0] kmd_seg(input kmd_char_t c);
        unique case (c)
            5'h00:         kmd_seg = 7'h3F;
            5'h01:         kmd_seg = 7'h06;
            5'h02:         kmd_seg = 7'h5B;
            5'h03:         kmd_seg = 7'h4F;
            5'h04:         kmd_seg = 7'h66;
            5'h05:         kmd_seg = 7'h6D;
            5'h06:         kmd_seg = 7'h7D;
            5'h07:         kmd_seg = 7'h07;
            5'h08:         kmd_seg = 7'h7F;
            5'h09:         kmd_seg = 7'h6F;
            `KMD_CH_MINUS: kmd_seg = 7'h40;
            `KMD_CH_E:     kmd_seg = 7'h79;
            `KMD_CH_N:     kmd_seg = 7'h54;
            `KMD_CH_D:     kmd_seg = 7'h5E;
            `KMD_CH_R:     kmd_seg = 7'h50;
            `KMD_CH_O:     kmd_seg = 7'h5C;
            `KMD_CH_P:     kmd_seg = 7'h73;
            `KMD_CH_C:     kmd_seg = 7'h39;
            `KMD_CH_S:     kmd_seg = 7'h6D;
            `KMD_CH_U:     kmd_seg = 7'h1C;
            `KMD_CH_A:     kmd_seg = 7'h77;
            `KMD_CH_L:     kmd_seg = 7'h38;
            `KMD_CH_B:     kmd_seg = 7'h7C;
            `KMD_CH_T:     kmd_seg = 7'h78;
            default:       kmd_seg = 7'h00;
        endcase
    endfunction : kmd_seg

    // ==========================================
    // Blink phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            blink_cnt_reg <= '0;
            blink_off_reg <= 1'b0;
        end else if (blink_cnt_reg == 32'(BLINK_CYCLES - 1)) begin
            blink_cnt_reg <= '0;
            blink_off_reg <= ~blink_off_reg;
        end else begin
            blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
        end
    end

    // ==========================================
    // Segment outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seg_out <= '0;
            dp_out  <= '0;
        end else begin
            for (int i = 0; i < 5; i++) begin
                seg_out[i] <= (blink_mask[i] && blink_off_reg) ? 7'h00
                                                               : kmd_seg(disp.chars[i]);
            end
            dp_out <= disp.dp;
        end
    end
endmodule : kmd_seg_drive

// *** core/kmd_controller.sv ***
// Keypad menu and five-digit display controller
`timescale 1ns/1ps
`include "kmd_consts.svh"
module kmd_controller
    import kmd_pkg::*;
#(
    parameter int MSG_CYCLES   = `KMD_MSG_CYCLES,
    parameter int DEB_CYCLES   = `KMD_DEB_CYCLES,
    parameter int BLINK_CYCLES = `KMD_BLINK_CYCLES,
    parameter int MON_COUNT    = `KMD_MON_COUNT,
    parameter int GROUP_COUNT  = `KMD_GROUP_COUNT,
    parameter int CODE_COUNT   = `KMD_CODE_COUNT
) (
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire kmd_keys_t       keys_raw,
    input  wire logic            fault_active,
    input  wire logic [4:0]      fault_code,
    input  wire logic            servo_running,
    input  wire logic            password_ok,
    input  wire kmd_value_t      mon_value,
    input  wire kmd_value_t      param_value,
    input  wire kmd_attr_t       param_attr,
    output logic      [4:0]      mon_sel,
    output logic      [2:0]      param_group,
    output logic      [5:0]      param_code,
    output logic                 param_wr,
    output kmd_value_t           param_wr_value,
    output logic                 cmd_exec,
    output logic      [4:0][6:0] seg_out,
    output logic      [4:0]      dp_out
);
    kmd_keys_t  key;
    kmd_state_t state_reg;
    kmd_state_t ret_reg;
    kmd_msg_t   msg_reg;
    kmd_msg_t   status;
    logic [31:0] timer_reg;
    kmd_value_t edit_reg;
    logic [2:0] cursor_reg;
    kmd_disp_t  disp;
    logic [4:0] blink_mask;
    logic       timer_done;

    // ==========================================
    // Helpers
    function automatic logic [3:0] kmd_digit_step(input logic [3:0] d, input logic up);
        if (up) begin
            kmd_digit_step = (d == 4'h9) ? 4'h0 : d + 4'h1;
        end else begin
            kmd_digit_step = (d == 4'h0) ? 4'h9 : d - 4'h1;
        end
    endfunction : kmd_digit_step

    function automatic logic [9:0] kmd_two_digits(input logic [5:0] n);
        logic [5:0] tens;
        logic [5:0] ones;
        tens = n / 6'd10;
        ones = n - tens * 6'd10;
        kmd_two_digits = {1'b0, tens[3:0], 1'b0, ones[3:0]};
    endfunction : kmd_two_digits

    function automatic kmd_disp_t kmd_fmt_value(input kmd_value_t v);
        kmd_disp_t r;
        r.chars = {1'b0, v.digits[4], 1'b0, v.digits[3], 1'b0, v.digits[2],
                   1'b0, v.digits[1], 1'b0, v.digits[0]};
        r.dp    = '0;
        if (v.neg && v.digits[4] != 4'h0) begin
            r.dp = 5'h1F;
        end else if (v.neg) begin
            r.chars[4] = `KMD_CH_MINUS;
        end
        kmd_fmt_value = r;
    endfunction : kmd_fmt_value

    function automatic logic [4:0][4:0] kmd_msg_text(input kmd_msg_t m);
        unique case (m)
            KMD_MSG_SAVED:     kmd_msg_text = {`KMD_CH_MINUS, `KMD_CH_E, `KMD_CH_N,
                                               `KMD_CH_D, `KMD_CH_MINUS};
            KMD_MSG_READ_ONLY: kmd_msg_text = {`KMD_CH_E, `KMD_CH_R, `KMD_CH_R,
                                               `KMD_CH_MINUS, `KMD_CH_R};
            KMD_MSG_BAD_PWD:   kmd_msg_text = {`KMD_CH_E, `KMD_CH_R, `KMD_CH_R,
                                               `KMD_CH_MINUS, `KMD_CH_P};
            KMD_MSG_INVALID:   kmd_msg_text = {`KMD_CH_E, `KMD_CH_R, `KMD_CH_R,
                                               `KMD_CH_MINUS, `KMD_CH_U};
            KMD_MSG_RUNNING:   kmd_msg_text = {`KMD_CH_S, `KMD_CH_R, `KMD_CH_U,
                                               `KMD_CH_O, `KMD_CH_N};
            KMD_MSG_NO_NV:     kmd_msg_text = {`KMD_CH_N, `KMD_CH_O, `KMD_CH_MINUS,
                                               `KMD_CH_E, `KMD_CH_E};
            KMD_MSG_RESTART:   kmd_msg_text = {`KMD_CH_P, `KMD_CH_O, `KMD_CH_MINUS,
                                               `KMD_CH_C, `KMD_CH_O};
            KMD_MSG_ABORT:     kmd_msg_text = {`KMD_CH_A, `KMD_CH_B, `KMD_CH_O,
                                               `KMD_CH_R, `KMD_CH_T};
        endcase
    endfunction : kmd_msg_text

    // ==========================================
    // Key presses and display driver
    kmd_key_edge #(
        .N          (5),
        .DEB_CYCLES (DEB_CYCLES)
    ) u_keys (
        .clk     (clk),
        .rst     (rst),
        .key_raw (keys_raw),
        .press   (key)
    );

    kmd_seg_drive #(
        .BLINK_CYCLES (BLINK_CYCLES)
    ) u_seg (
        .clk        (clk),
        .rst        (rst),
        .disp       (disp),
        .blink_mask (blink_mask),
        .seg_out    (seg_out),
        .dp_out     (dp_out)
    );

    // ==========================================
    // Commit status, first refusal wins
    always_comb begin
        if (param_attr.read_only) begin
            status = KMD_MSG_READ_ONLY;
        end else if (param_attr.pwd_req && !password_ok) begin
            status = KMD_MSG_BAD_PWD;
        end else if (param_attr.run_lock && servo_running) begin
            status = KMD_MSG_RUNNING;
        end else if (edit_reg.neg && !param_attr.signed_ok) begin
            status = KMD_MSG_INVALID;
        end else if (param_attr.volatile_only) begin
            status = KMD_MSG_NO_NV;
        end else if (param_attr.restart_req) begin
            status = KMD_MSG_RESTART;
        end else begin
            status = KMD_MSG_SAVED;
        end
    end

    assign timer_done = (timer_reg == 32'(MSG_CYCLES - 1));

    // ==========================================
    // Menu state machine
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= KMD_ST_MON_SYM;
            ret_reg   <= KMD_ST_MONITOR;
            msg_reg   <= KMD_MSG_SAVED;
        end else begin
            unique case (state_reg)
                KMD_ST_MON_SYM: begin
                    if (timer_done) begin
                        state_reg <= KMD_ST_MONITOR;
                    end
                end
                KMD_ST_MONITOR: begin
                    if (key.mode) begin
                        state_reg <= KMD_ST_PARAM;
                    end else if (key.up || key.down) begin
                        state_reg <= KMD_ST_MON_SYM;
                    end
                end
                KMD_ST_PARAM: begin
                    if (key.mode) begin
                        state_reg <= KMD_ST_MSG;
                        msg_reg   <= KMD_MSG_ABORT;
                        ret_reg   <= KMD_ST_MONITOR;
                    end else if (key.set) begin
                        state_reg <= KMD_ST_SET;
                    end
                end
                KMD_ST_SET: begin
                    if (key.mode) begin
                        state_reg <= KMD_ST_PARAM;
                    end else if (key.set) begin
                        state_reg <= KMD_ST_MSG;
                        msg_reg   <= status;
                        ret_reg   <= KMD_ST_PARAM;
                    end
                end
                KMD_ST_MSG: begin
                    if (timer_done) begin
                        state_reg <= ret_reg;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // One-second message timer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timer_reg <= '0;
        end else if ((state_reg == KMD_ST_MON_SYM || state_reg == KMD_ST_MSG)
                     && !timer_done) begin
            timer_reg <= timer_reg + 32'h0000_0001;
        end else begin
            timer_reg <= '0;
        end
    end

    // ==========================================
    // Monitor selection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mon_sel <= '0;
        end else if (state_reg == KMD_ST_MONITOR && !key.mode) begin
            if (key.up) begin
                mon_sel <= (mon_sel == 5'(MON_COUNT - 1)) ? 5'h00 : mon_sel + 5'h01;
            end else if (key.down) begin
                mon_sel <= (mon_sel == 5'h00) ? 5'(MON_COUNT - 1) : mon_sel - 5'h01;
            end
        end
    end

    // ==========================================
    // Parameter group and code
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            param_group <= '0;
            param_code  <= '0;
        end else if (state_reg == KMD_ST_PARAM && !key.mode && !key.set) begin
            if (key.shift) begin
                param_group <= (param_group == 3'(GROUP_COUNT - 1)) ? 3'h0
                                                                    : param_group + 3'h1;
                param_code  <= '0;
            end else if (key.up) begin
                param_code <= (param_code == 6'(CODE_COUNT - 1)) ? 6'h00
                                                                 : param_code + 6'h01;
            end else if (key.down) begin
                param_code <= (param_code == 6'h00) ? 6'(CODE_COUNT - 1)
                                                    : param_code - 6'h01;
            end
        end
    end

    // ==========================================
    // Edit buffer and cursor
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            edit_reg   <= '0;
            cursor_reg <= '0;
        end else if (state_reg == KMD_ST_PARAM && key.set && !key.mode) begin
            edit_reg   <= param_value;
            cursor_reg <= '0;
        end else if (state_reg == KMD_ST_SET && !key.mode && !key.set) begin
            if (key.shift) begin
                cursor_reg <= (cursor_reg == 3'(`KMD_SIGN_POS)) ? 3'h0
                                                                : cursor_reg + 3'h1;
            end else if ((key.up || key.down) && cursor_reg == 3'(`KMD_SIGN_POS)) begin
                edit_reg.neg <= ~edit_reg.neg;
            end else if (key.up || key.down) begin
                edit_reg.digits[cursor_reg] <=
                    kmd_digit_step(edit_reg.digits[cursor_reg], key.up);
            end
        end
    end

    // ==========================================
    // Store write and command strobes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            param_wr       <= 1'b0;
            cmd_exec       <= 1'b0;
            param_wr_value <= '0;
        end else begin
            param_wr <= 1'b0;
            cmd_exec <= 1'b0;
            if (state_reg == KMD_ST_SET && key.set && !key.mode) begin
                param_wr_value <= edit_reg;
                if (status == KMD_MSG_SAVED || status == KMD_MSG_NO_NV
                    || status == KMD_MSG_RESTART) begin
                    param_wr <= ~param_attr.command;
                    cmd_exec <= param_attr.command;
                end
            end
        end
    end

    // ==========================================
    // Display content
    always_comb begin
        disp       = '0;
        blink_mask = '0;
        unique case (state_reg)
            KMD_ST_MON_SYM: begin
                disp.chars = {`KMD_CH_C, `KMD_CH_D, `KMD_CH_MINUS,
                              kmd_two_digits({1'b0, mon_sel})};
            end
            KMD_ST_MONITOR: begin
                if (fault_active) begin
                    disp.chars = {`KMD_CH_A, `KMD_CH_L, `KMD_CH_E,
                                  kmd_two_digits({1'b0, fault_code})};
                end else begin
                    disp = kmd_fmt_value(mon_value);
                end
            end
            KMD_ST_PARAM: begin
                disp.chars = {`KMD_CH_P, 2'b00, param_group, `KMD_CH_MINUS,
                              kmd_two_digits(param_code)};
            end
            KMD_ST_SET: begin
                disp       = kmd_fmt_value(edit_reg);
                blink_mask = (cursor_reg == 3'(`KMD_SIGN_POS)) ? 5'h10
                                                               : 5'h01 << cursor_reg;
            end
            KMD_ST_MSG: begin
                disp.chars = kmd_msg_text(msg_reg);
            end
            default: begin
                disp = '0;
            end
        endcase
    end
endmodule : kmd_controller

// *** test/kmd_controller_chk.sv ***
// Port assertions for the keypad menu display controller
`timescale 1ns/1ps
module kmd_controller_chk
    import kmd_pkg::*;
#(
    parameter int MON_COUNT   = 17,
    parameter int GROUP_COUNT = 5,
    parameter int CODE_COUNT  = 64
) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       servo_running,
    input wire logic       password_ok,
    input wire kmd_attr_t  param_attr,
    input wire logic [4:0] mon_sel,
    input wire logic [2:0] param_group,
    input wire logic [5:0] param_code,
    input wire logic       param_wr,
    input wire kmd_value_t param_wr_value,
    input wire logic       cmd_exec
);
    // ==========================================
    // Write and command strobes, selection range
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_wr_one_cycle:
        assert property (param_wr |=> !param_wr) else $error("write strobe too long");
    a_cmd_one_cycle:
        assert property (cmd_exec |=> !cmd_exec) else $error("command strobe too long");
    a_cmd_no_write:
        assert property (cmd_exec |-> !param_wr) else $error("command also wrote");
    a_ro_no_write:
        assert property (param_wr |-> !param_attr.read_only) else $error("read-only written");
    a_pwd_no_write:
        assert property (param_wr |-> !(param_attr.pwd_req && !password_ok))
        else $error("write without password");
    a_run_no_write:
        assert property (param_wr |-> !(param_attr.run_lock && servo_running))
        else $error("locked write while running");
    a_bad_no_write:
        assert property (param_wr |-> !(param_wr_value.neg && !param_attr.signed_ok))
        else $error("invalid value written");
    a_value_held:
        assert property (param_wr |=> $stable(param_wr_value)) else $error("value moved");
    a_sel_range:
        assert property (mon_sel < MON_COUNT && param_group < GROUP_COUNT
                         && param_code < CODE_COUNT) else $error("selection out of range");
endmodule : kmd_controller_chk

// *** test/kmd_store_model.sv ***
// Parameter store model on the far side of the controller
`timescale 1ns/1ps
module kmd_store_model
    import kmd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [5:0] param_code,
    input  wire logic       param_wr,
    input  wire kmd_value_t param_wr_value,
    output kmd_value_t      param_value,
    output kmd_attr_t       param_attr
);
    kmd_value_t store_reg [0:63];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 64; i++) begin
                store_reg[i] <= {1'b0, 20'h0_0042};
            end
            store_reg[0] <= {1'b1, 20'h1_2345};
            store_reg[7] <= {1'b1, 20'h0_0007};
        end else if (param_wr) begin
            store_reg[param_code] <= param_wr_value;
        end
    end
    assign param_value = store_reg[param_code];
    // Code 1 read-only, 2 password, 3 run lock, 4 command, 6 restart, 7 unsigned
    always_comb begin
        param_attr = '0;
        param_attr.signed_ok = (param_code != 6'h07);
        param_attr.read_only = (param_code == 6'h01);
        param_attr.pwd_req = (param_code == 6'h02);
        param_attr.run_lock = (param_code == 6'h03);
        param_attr.command = (param_code == 6'h04);
        param_attr.restart_req = (param_code == 6'h06);
    end
endmodule : kmd_store_model

// *** test/kmd_controller_tb.sv ***
// Self-checking bench for the keypad menu display controller
`timescale 1ns/1ps
module kmd_controller_tb;
    import kmd_pkg::*;
    logic            clk;
    logic            rst;
    kmd_keys_t       keys_raw;
    logic [4:0]      mon_sel;
    logic [2:0]      param_group;
    logic [5:0]      param_code;
    logic            param_wr;
    logic            cmd_exec;
    kmd_value_t      param_value;
    kmd_value_t      param_wr_value;
    kmd_attr_t       param_attr;
    logic [4:0][6:0] seg_out;
    logic [4:0]      dp_out;
    logic            fault_active = 1'b0;
    logic [4:0]      fault_code = 5'h00;
    logic            servo_running = 1'b1;
    logic            password_ok = 1'b0;
    int              error_cnt = 0;
    int              check_count = 0;
    int              wr_cnt = 0;
    int              cmd_cnt = 0;
    kmd_controller #(.MSG_CYCLES(20), .DEB_CYCLES(2), .BLINK_CYCLES(4)) kmd_controller_inst (
        .clk, .rst, .keys_raw, .fault_active, .fault_code, .servo_running,
        .password_ok, .mon_value('0), .param_value, .param_attr, .mon_sel, .param_group,
        .param_code, .param_wr, .param_wr_value, .cmd_exec, .seg_out, .dp_out);
    kmd_store_model kmd_store_model_inst (.clk, .rst, .param_code, .param_wr, .param_wr_value,
        .param_value, .param_attr);
    // ==========================================
    // Clock, strobe counters, shared tasks
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (param_wr === 1'b1) wr_cnt++;
        if (cmd_exec === 1'b1) cmd_cnt++;
    end
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic press(input logic [4:0] k);
        keys_raw <= k;
        repeat (5) @(posedge clk);
        keys_raw <= '0;
        repeat (5) @(posedge clk);
    endtask : press
    task automatic complete_run;
        $display("mismatches %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    // ==========================================
    // Scenarios
    task automatic t_power_on;
        press(5'b00100);
        chk(mon_sel, 0);
        chk(seg_out[4], 7'h39);
        repeat (20) @(posedge clk);
        chk(seg_out[4], 7'h3F);
        press(5'b00100);
        chk(mon_sel, 1);
        chk(seg_out[0], 7'h06);
        repeat (20) @(posedge clk);
        press(5'b00010);
        chk(mon_sel, 0);
        repeat (20) @(posedge clk);
    endtask : t_power_on
    task automatic t_edit;
        press(5'b10000);
        press(5'b01000);
        chk(param_group, 1);
        press(5'b00001);
        chk(dp_out, 5'h1F);
        press(5'b00100);
        press(5'b10000);
        press(5'b00001);
        chk(dp_out, 5'h1F);
        press(5'b00100);
        press(5'b01000);
        press(5'b00100);
        chk(wr_cnt, 0);
        press(5'b00001);
        chk(wr_cnt, 1);
        chk(param_wr_value, 32'h0011_2356);
        chk(seg_out[3], 7'h79);
        repeat (20) @(posedge clk);
        chk(dp_out, 0);
        chk(seg_out[4], 7'h73);
    endtask : t_edit
    task automatic t_status;
        int w;
        int m;
        for (int c = 1; c <= 7; c++) begin
            w = wr_cnt;
            m = cmd_cnt;
            press(5'b00100);
            chk(param_code, c);
            press(5'b00001);
            press(5'b00100);
            press(5'b00001);
            chk(seg_out[0], (c == 1) ? 7'h50 : (c == 2) ? 7'h73 : (c == 3) ? 7'h54
                : (c == 6) ? 7'h5C : (c == 7) ? 7'h1C : 7'h40);
            repeat (20) @(posedge clk);
            chk(wr_cnt - w, (c == 5 || c == 6));
            chk(cmd_cnt - m, (c == 4));
            chk(param_value[7:0], (c == 7) ? 8'h07 : (c > 4 ? 8'h43 : 8'h42));
            if (c == 2 || c == 3) begin
                password_ok <= 1'b1;
                servo_running <= 1'b0;
                press(5'b00001);
                press(5'b00001);
                repeat (20) @(posedge clk);
                chk(wr_cnt - w, 1);
                password_ok <= 1'b0;
                servo_running <= 1'b1;
            end
        end
    endtask : t_status
    task automatic t_sign;
        logic lit;
        logic dark;
        lit = 1'b0;
        dark = 1'b0;
        press(5'b00100);
        press(5'b00001);
        repeat (5) press(5'b01000);
        press(5'b00100);
        repeat (10) begin
            @(negedge clk);
            lit |= (seg_out[4] === 7'h40);
            dark |= (seg_out[4] === 7'h00);
        end
        @(posedge clk);
        chk(lit, 1);
        chk(dark, 1);
        chk(dp_out, 0);
        press(5'b00001);
        chk(param_wr_value, 32'h0010_0042);
        repeat (20) @(posedge clk);
        press(5'b10000);
        chk(seg_out[4], 7'h77);
        repeat (20) @(posedge clk);
        press(5'b00100);
        chk(mon_sel, 1);
        chk(param_code, 8);
    endtask : t_sign
    task automatic t_fault;
        fault_active <= 1'b1;
        fault_code <= 5'h16;
        repeat (25) @(posedge clk);
        chk(seg_out[4], 7'h77);
        chk(seg_out[0], 7'h5B);
    endtask : t_fault
    initial begin
        rst = 1'b1;
        keys_raw = '0;
        repeat (2) @(posedge clk);
        chk(seg_out, 0);
        chk(dp_out, 0);
        rst <= 1'b0;
        t_power_on();
        t_edit();
        t_status();
        t_sign();
        t_fault();
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        $display("unexpected at %0t: run too long", $time);
        complete_run();
    end
endmodule : kmd_controller_tb
bind kmd_controller kmd_controller_chk #(.MON_COUNT(MON_COUNT), .GROUP_COUNT(GROUP_COUNT),
    .CODE_COUNT(CODE_COUNT)) kmd_controller_chk_inst (.clk, .rst, .servo_running, .password_ok,
    .param_attr, .mon_sel, .param_group, .param_code, .param_wr, .param_wr_value, .cmd_exec);
